// file: rtl/sbs_sequencer.sv
// burst column sequencer with mode register and read latency pipeline
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"
module sbs_sequencer #(
    parameter int COL_MSB = `SBS_COL_MSB_LARGE,
    parameter int DQ_W = 16,
    parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // command bus from the controller
    input wire logic cmd_read,
    input wire logic cmd_write,
    input wire logic cmd_stop,
    input wire logic cmd_load_mode,
    input wire logic [`SBS_MODE_W-1:0] cmd_addr,
    input wire logic [DQ_W-1:0] dq_in,
    // data pins and status toward the controller
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic wr_ready,
    output logic burst_busy,
    // cell array read port, data returned in the same cycle
    output logic arr_rd_en,
    output logic [COL_MSB:0] arr_rd_addr,
    input wire logic [DQ_W-1:0] arr_rdata,
    // cell array write port
    output logic arr_wr_valid,
    output logic [COL_MSB:0] arr_wr_addr,
    output logic [DQ_W-1:0] arr_wr_data,
    input wire logic arr_wr_ready
);
    import sbs_pkg::*;

    localparam int COL_W = COL_MSB + 1;

    // mode register fields
    sbs_bl_t bl_ff;
    logic intl_ff;
    logic [2:0] lat_ff;
    logic wbm_ff;
    // burst generator state
    sbs_state_t state_ff;
    sbs_state_t nxt_state;
    logic [COL_MSB:0] start_ff;
    logic [COL_MSB:0] nxt_start;
    logic [COL_MSB:0] beat_ff;
    logic [COL_MSB:0] nxt_beat;
    sbs_bl_t eff_ff;
    sbs_bl_t nxt_eff;
    logic [COL_MSB:0] col_ff;
    logic [COL_MSB:0] nxt_col;
    logic col_v_ff;
    logic nxt_col_v;
    logic wr_ff;
    logic nxt_wr;
    logic [DQ_W-1:0] wdata_ff;
    logic [DQ_W-1:0] nxt_wdata;
    // read data pipeline
    logic rd_en_ff;
    logic p1_v_ff;
    logic [DQ_W-1:0] p1_d_ff;
    logic dq_oe_ff;
    logic [DQ_W-1:0] dq_out_ff;
    // glue
    logic cmd_go;
    logic stall;
    logic fifo_rdy;
    logic load_take;
    logic lat3;
    logic [COL_MSB:0] gen_start;
    logic [COL_MSB:0] gen_beat;
    sbs_bl_t gen_bl;
    logic [COL_MSB:0] gen_col;

    // block mask of a length code, all ones for a whole page
    function automatic logic [COL_MSB:0] blk_mask(input sbs_bl_t c);
        if (sbs_is_page(c)) begin
            blk_mask = '1;
        end else begin
            blk_mask = COL_W'((1 << sbs_blk_log2(c)) - 1);
        end
    endfunction

    assign cmd_go = cmd_read || cmd_write;
    // a write beat the fifo cannot take freezes the generator
    assign stall = col_v_ff && wr_ff && !fifo_rdy;
    // the mode is only taken while no burst runs and in the normal mode
    assign load_take = cmd_load_mode && !cmd_go && !cmd_stop && !stall
        && (state_ff == ST_IDLE)
        && (cmd_addr[`SBS_OPM_MSB:`SBS_OPM_LSB] == `SBS_OPM_NORMAL);
    // reserved latency codes fall back to the slower setting
    assign lat3 = (lat_ff != `SBS_LAT_2);

    // mode register, loaded from the address lines
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bl_ff <= `SBS_BL_1;
            intl_ff <= 1'b0;
            lat_ff <= `SBS_LAT_2;
            wbm_ff <= 1'b0;
        end else if (load_take) begin
            bl_ff <= cmd_addr[`SBS_BL_MSB:`SBS_BL_LSB];
            intl_ff <= cmd_addr[`SBS_ORDER_BIT];
            lat_ff <= cmd_addr[`SBS_LAT_MSB:`SBS_LAT_LSB];
            wbm_ff <= cmd_addr[`SBS_WBM_BIT];
        end
    end

    // one generator serves both the first column and the later beats
    assign gen_start = cmd_go ? cmd_addr[COL_MSB:0] : start_ff;
    assign gen_beat = cmd_go ? '0 : COL_W'(beat_ff + 1'b1);
    assign gen_bl = cmd_go ? nxt_eff : eff_ff;

    sbs_colgen #(.COL_W(COL_W)) u_colgen (
        .start(gen_start),
        .beat(gen_beat),
        .bl_code(gen_bl),
        .order_intl(intl_ff),
        .col(gen_col)
    );

    // next beat: new command, stop, or the next column of a running burst
    always_comb begin
        nxt_state = state_ff;
        nxt_start = start_ff;
        nxt_beat = beat_ff;
        nxt_eff = eff_ff;
        nxt_col = col_ff;
        nxt_col_v = 1'b0;
        nxt_wr = wr_ff;
        nxt_wdata = wdata_ff;
        if (cmd_go) begin
            // single-location writes when the write burst bit is set
            nxt_eff = (cmd_write && wbm_ff) ? `SBS_BL_1 : bl_ff;
        end
        if (stall) begin
            nxt_col_v = 1'b1;
        end else if (cmd_go) begin
            nxt_start = cmd_addr[COL_MSB:0];
            nxt_beat = '0;
            nxt_col = gen_col;
            nxt_col_v = 1'b1;
            nxt_wr = cmd_write;
            nxt_wdata = dq_in;
            nxt_state = (blk_mask(nxt_eff) == '0) ? ST_IDLE : ST_BURST;
        end else if (cmd_stop) begin
            nxt_state = ST_IDLE;
        end else begin
            case (state_ff)
                ST_BURST: begin
                    nxt_beat = gen_beat;
                    nxt_col = gen_col;
                    nxt_col_v = 1'b1;
                    nxt_wdata = dq_in;
                    // a whole page runs until stopped, wrapping in the row
                    if (!sbs_is_page(eff_ff) && gen_beat == blk_mask(eff_ff)) begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    // burst generator registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            start_ff <= '0;
            beat_ff <= '0;
            eff_ff <= `SBS_BL_1;
            col_ff <= '0;
            col_v_ff <= 1'b0;
            wr_ff <= 1'b0;
            wdata_ff <= '0;
            rd_en_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            start_ff <= nxt_start;
            beat_ff <= nxt_beat;
            eff_ff <= nxt_eff;
            col_ff <= nxt_col;
            col_v_ff <= nxt_col_v;
            wr_ff <= nxt_wr;
            wdata_ff <= nxt_wdata;
            rd_en_ff <= nxt_col_v && !nxt_wr && !stall;
        end
    end

    // read pipeline: one extra stage when the latency is three
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            p1_v_ff <= 1'b0;
            p1_d_ff <= '0;
            dq_oe_ff <= 1'b0;
            dq_out_ff <= '0;
        end else begin
            p1_v_ff <= rd_en_ff;
            p1_d_ff <= arr_rdata;
            dq_oe_ff <= lat3 ? p1_v_ff : rd_en_ff;
            dq_out_ff <= lat3 ? p1_d_ff : arr_rdata;
        end
    end

    // write beats queue here so a slow array back-pressures the controller
    sbs_fifo #(.W(COL_W + DQ_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(col_v_ff && wr_ff),
        .in_ready(fifo_rdy),
        .in_data({col_ff, wdata_ff}),
        .out_valid(arr_wr_valid),
        .out_ready(arr_wr_ready),
        .out_data({arr_wr_addr, arr_wr_data})
    );

    assign wr_ready = fifo_rdy;
    assign dq_out = dq_out_ff;
    assign dq_oe = dq_oe_ff;
    assign burst_busy = col_v_ff;
    assign arr_rd_en = rd_en_ff;
    assign arr_rd_addr = col_ff;

    // checks next to the logic they guard
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_mode_load;
        load_take |=> bl_ff == $past(cmd_addr[`SBS_BL_MSB:`SBS_BL_LSB])
            && intl_ff == $past(cmd_addr[`SBS_ORDER_BIT])
            && lat_ff == $past(cmd_addr[`SBS_LAT_MSB:`SBS_LAT_LSB]);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode field not loaded");

    property p_first_col;
        cmd_go && !stall |=> col_v_ff && col_ff == $past(cmd_addr[COL_MSB:0]);
    endproperty
    a_first_col: assert property (p_first_col) else $error("first column wrong");

    property p_block;
        col_v_ff |-> (col_ff & ~blk_mask(eff_ff)) == (start_ff & ~blk_mask(eff_ff));
    endproperty
    a_block: assert property (p_block) else $error("column left its block");

    property p_length;
        col_v_ff && !sbs_is_page(eff_ff) |-> beat_ff <= blk_mask(eff_ff);
    endproperty
    a_length: assert property (p_length) else $error("burst ran past its length");

    property p_intl;
        col_v_ff && intl_ff && !sbs_is_page(eff_ff)
            |-> (col_ff & blk_mask(eff_ff)) == ((start_ff ^ beat_ff) & blk_mask(eff_ff));
    endproperty
    a_intl: assert property (p_intl) else $error("interleaved order wrong");

    property p_seq;
        state_ff == ST_BURST && !intl_ff && !stall && !cmd_go && !cmd_stop
            |=> (col_ff & blk_mask(eff_ff))
                == (COL_W'($past(col_ff) + 1'b1) & blk_mask(eff_ff));
    endproperty
    a_seq: assert property (p_seq) else $error("sequential step wrong");

    property p_single;
        cmd_go && !stall && blk_mask(nxt_eff) == '0 ##1 !cmd_go |=> !col_v_ff;
    endproperty
    a_single: assert property (p_single) else $error("length one gave extra beat");

    property p_page_wrap;
        state_ff == ST_BURST && sbs_is_page(eff_ff) && col_ff == '1
            && !stall && !cmd_go && !cmd_stop |=> col_v_ff && col_ff == '0;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page did not wrap");

    property p_rd_lat2;
        cmd_read && !stall && !lat3 ##1 !load_take |-> ##1 dq_oe_ff
            && dq_out_ff == $past(arr_rdata);
    endproperty
    a_rd_lat2: assert property (p_rd_lat2) else $error("latency two timing wrong");

    property p_rd_lat3;
        cmd_read && !stall && lat3 |-> ##3 dq_oe_ff && dq_out_ff == $past(arr_rdata, 2);
    endproperty
    a_rd_lat3: assert property (p_rd_lat3) else $error("latency three timing wrong");

    property p_stop;
        cmd_stop && !cmd_go && !stall |=> !col_v_ff;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end burst");

    c_intl_burst: cover property (cmd_read && intl_ff && bl_ff == `SBS_BL_8 ##8 dq_oe_ff);
    c_page_wrap: cover property (sbs_is_page(eff_ff) && col_v_ff && col_ff == '1 ##1 col_ff == '0);
    c_lat3_read: cover property (cmd_read && lat3 ##3 dq_oe_ff);
    c_write_stall: cover property (stall);
endmodule
`default_nettype wire

// file: rtl/sbs_params.svh
// constants for the burst column sequencer
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
`define SBS_MODE_W 12
`define SBS_BL_LSB 0
`define SBS_BL_MSB 2
`define SBS_ORDER_BIT 3
`define SBS_LAT_LSB 4
`define SBS_LAT_MSB 6
`define SBS_OPM_LSB 7
`define SBS_OPM_MSB 8
`define SBS_WBM_BIT 9
`define SBS_BL_1 3'h0
`define SBS_BL_2 3'h1
`define SBS_BL_4 3'h2
`define SBS_BL_8 3'h3
`define SBS_BL_PAGE 3'h7
`define SBS_LAT_2 3'h2
`define SBS_LAT_3 3'h3
`define SBS_OPM_NORMAL 2'h0
`define SBS_COL_MSB_SMALL 7
`define SBS_COL_MSB_LARGE 8
`define SBS_FIFO_DEPTH 16
`endif

// file: rtl/sbs_pkg.sv
// types and burst-length decode shared by the sequencer files
`include "sbs_params.svh"
package sbs_pkg;
    typedef logic [2:0] sbs_bl_t;
    typedef enum logic {ST_IDLE, ST_BURST} sbs_state_t;

    // log2 of the block size; reserved codes behave as length one
    function automatic logic [1:0] sbs_blk_log2(input sbs_bl_t c);
        case (c)
            `SBS_BL_2: sbs_blk_log2 = 2'h1;
            `SBS_BL_4: sbs_blk_log2 = 2'h2;
            `SBS_BL_8: sbs_blk_log2 = 2'h3;
            default: sbs_blk_log2 = 2'h0;
        endcase
    endfunction

    function automatic logic sbs_is_page(input sbs_bl_t c);
        sbs_is_page = (c == `SBS_BL_PAGE);
    endfunction
endpackage

// file: rtl/sbs_colgen.sv
// column address generator: block bits kept, low bits ordered
`timescale 1ns/1ps
`default_nettype none
module sbs_colgen #(
    parameter int COL_W = 9
) (
    // burst start, beat count and mode
    input wire logic [COL_W-1:0] start,
    input wire logic [COL_W-1:0] beat,
    input wire sbs_pkg::sbs_bl_t bl_code,
    input wire logic order_intl,
    // resulting column
    output logic [COL_W-1:0] col
);
    import sbs_pkg::*;

    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] low;

    // length one gives an empty mask, so the order bit has no effect
    always_comb begin
        if (sbs_is_page(bl_code)) begin
            mask = '1;
        end else begin
            mask = COL_W'((1 << sbs_blk_log2(bl_code)) - 1);
        end
        // whole page has no interleaved form, so it always counts up
        if (order_intl && !sbs_is_page(bl_code)) begin
            low = start ^ beat;
        end else begin
            low = COL_W'(start + beat);
        end
        col = (start & ~mask) | (low & mask);
    end
endmodule
`default_nettype wire

// file: rtl/sbs_fifo.sv
// write-beat fifo between the column sequencer and the cell array
`timescale 1ns/1ps
`default_nettype none
module sbs_fifo #(
    parameter int W = 25,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0] cnt_ff;
    logic full_ff;
    logic empty_ff;
    logic push;
    logic pop;
    logic [AW:0] nxt_cnt;

    assign push = in_valid && !full_ff;
    assign pop = !empty_ff && out_ready;
    assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = !full_ff;
    assign out_valid = !empty_ff;
    assign out_data = mem[rptr_ff];

    // storage needs no reset; only slots behind the pointers are read
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wptr_ff] <= in_data;
        end
    end

    // pointers and flags kept as flops so the port levels are clean
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
        end else begin
            if (push) begin
                wptr_ff <= (wptr_ff == AW'(DEPTH - 1)) ? '0 : AW'(wptr_ff + 1'b1);
            end
            if (pop) begin
                rptr_ff <= (rptr_ff == AW'(DEPTH - 1)) ? '0 : AW'(rptr_ff + 1'b1);
            end
            cnt_ff <= nxt_cnt;
            full_ff <= (nxt_cnt == (AW+1)'(DEPTH));
            empty_ff <= (nxt_cnt == '0);
        end
    end
endmodule
`default_nettype wire

// file: verif/sbs_host_model.sv
// host controller and cell array stand-in for the burst sequencer bench
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model (
    // clock
    input wire logic mclk,
    // command bus toward the sequencer
    output logic cmd_read,
    output logic cmd_write,
    output logic cmd_stop,
    output logic cmd_load_mode,
    output logic [11:0] cmd_addr,
    output logic [15:0] dq_in,
    // cell array read port
    input wire logic arr_rd_en,
    input wire logic [8:0] arr_rd_addr,
    output logic [15:0] arr_rdata
);
    // quiet bus at time zero
    initial begin
        {cmd_read, cmd_write, cmd_stop, cmd_load_mode} = 4'h0;
        cmd_addr = 12'h000;
        dq_in = 16'h0000;
    end

    // array answers in the same cycle; unselected reads give the inverse so stale data fails
    always_comb begin
        arr_rdata = {4'ha, 3'h0, arr_rd_addr};
        if (!arr_rd_en) begin
            arr_rdata = ~arr_rdata;
        end
    end

    // one-cycle command, kind is {load, stop, write, read}; address inverted once released
    task automatic cmd(input logic [3:0] kind, input logic [11:0] addr);
        @(negedge mclk);
        {cmd_load_mode, cmd_stop, cmd_write, cmd_read} = kind;
        cmd_addr = addr;
        @(negedge mclk);
        {cmd_load_mode, cmd_stop, cmd_write, cmd_read} = 4'h0;
        cmd_addr = ~addr;
    endtask

    // only defined length and latency codes are sent; a nonzero mode field only to be refused
    task automatic load_mode(input logic [2:0] bl, input logic intl, input logic [2:0] lat,
                             input logic [1:0] opm, input logic wbm);
        cmd(4'h8, {2'h0, wbm, opm, lat, intl, bl});
    endtask

    // write burst: data of beat k is presented k cycles after the command
    task automatic wr_burst(input logic [11:0] addr, input int len, input logic [15:0] base);
        for (int k = 0; k < len; k++) begin
            @(negedge mclk);
            cmd_write = (k == 0);
            cmd_addr = (k == 0) ? addr : ~cmd_addr;
            dq_in = base + 16'(k);
        end
        @(negedge mclk);
        cmd_write = 1'b0;
        cmd_addr = ~cmd_addr;
        dq_in = ~dq_in;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the burst column sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"
module tb_top;
    import sbs_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic arr_wr_ready = 1'b0;
    logic cmd_read, cmd_write, cmd_stop, cmd_load_mode;
    logic [11:0] cmd_addr;
    logic [15:0] dq_in, dq_out, arr_rdata, arr_wr_data;
    logic dq_oe, wr_ready, burst_busy, arr_rd_en, arr_wr_valid;
    logic [8:0] arr_rd_addr, arr_wr_addr;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    sbs_sequencer #(.COL_MSB(8), .DQ_W(16), .FIFO_DEPTH(16)) dut (
        .mclk(mclk), .rstn(rstn), .cmd_read(cmd_read), .cmd_write(cmd_write),
        .cmd_stop(cmd_stop), .cmd_load_mode(cmd_load_mode), .cmd_addr(cmd_addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .wr_ready(wr_ready),
        .burst_busy(burst_busy), .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr),
        .arr_rdata(arr_rdata), .arr_wr_valid(arr_wr_valid), .arr_wr_addr(arr_wr_addr),
        .arr_wr_data(arr_wr_data), .arr_wr_ready(arr_wr_ready));

    sbs_host_model host (
        .mclk(mclk), .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_stop(cmd_stop),
        .cmd_load_mode(cmd_load_mode), .cmd_addr(cmd_addr), .dq_in(dq_in),
        .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr), .arr_rdata(arr_rdata));

    task automatic conclude();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // block bits kept, low bits ordered; a 512 page is one big sequential block
    function automatic logic [8:0] exp_col(input logic [8:0] s, input int len,
                                           input logic intl, input int k);
        logic [8:0] m;
        m = 9'(len - 1);
        return (s & ~m) | (intl ? ((s ^ 9'(k)) & m) : ((s + 9'(k)) & m));
    endfunction

    // one read burst, columns and the latency-shifted data judged cycle by cycle
    task automatic run_read(input logic [8:0] s, input int len, input logic intl, input int lat);
        logic win;
        host.cmd(4'h1, {3'h0, s});
        for (int i = 0; i <= len + lat; i++) begin
            win = (i >= lat - 1) && (i < lat - 1 + len);
            check(arr_rd_en, i < len, "read strobe");
            if (i < len) begin
                check(arr_rd_addr, exp_col(s, len, intl, i), "column");
            end
            check(dq_oe, win, "dq enable");
            if (win) begin
                check(dq_out, 16'ha000 | exp_col(s, len, intl, i - lat + 1), "read data");
            end
            @(negedge mclk);
        end
    endtask

    task automatic t_reset();
        check({burst_busy, dq_oe, wr_ready, arr_wr_valid, arr_rd_en}, 5'b00100, "reset outputs");
    endtask

    // every fixed length, both orders; latency two starts at the block top 1ff, latency three at column 0a6
    task automatic t_reads();
        logic [2:0] codes [4] = '{`SBS_BL_1, `SBS_BL_2, `SBS_BL_4, `SBS_BL_8};
        logic [8:0] starts [2] = '{9'h1ff, 9'h0a6};
        for (int c = 0; c < 4; c++) begin
            for (int o = 0; o < 2; o++) begin
                for (int j = 0; j < 2; j++) begin
                    host.load_mode(codes[c], o[0], j ? `SBS_LAT_3 : `SBS_LAT_2, 2'h0, 1'b0);
                    run_read(starts[j], 1 << c, o[0], 2 + j);
                end
            end
        end
    endtask

    // whole page wraps at 512 and is cut short by a stop
    task automatic t_page();
        host.load_mode(`SBS_BL_PAGE, 1'b0, `SBS_LAT_3, 2'h0, 1'b0);
        host.cmd(4'h1, 12'h1fe);
        for (int i = 0; i < 6; i++) begin
            check(arr_rd_addr, exp_col(9'h1fe, 512, 1'b0, i), "page column");
            if (i < 5) begin
                @(negedge mclk);
            end
        end
        host.cmd(4'h4, 12'h000);
        repeat (2) @(negedge mclk);
        check({burst_busy, arr_rd_en}, 2'b00, "burst stopped");
        repeat (4) @(negedge mclk);
        check(dq_oe, 1'b0, "drive released");
    endtask

    // a load with a nonzero operating mode must leave the length-four mode in place
    task automatic t_refused();
        host.load_mode(`SBS_BL_4, 1'b0, `SBS_LAT_2, 2'h0, 1'b0);
        host.load_mode(`SBS_BL_8, 1'b1, `SBS_LAT_3, 2'h1, 1'b0);
        run_read(9'h001, 4, 1'b0, 2);
    endtask

    // fill the fifo with two write bursts while the array stalls, then drain with stalls
    task automatic t_fifo();
        logic [24:0] exp_q [$];
        int n;
        arr_wr_ready = 1'b0;
        host.load_mode(`SBS_BL_8, 1'b0, `SBS_LAT_2, 2'h0, 1'b0);
        host.wr_burst(12'h005, 8, 16'h1000);
        repeat (2) @(negedge mclk);
        host.load_mode(`SBS_BL_8, 1'b1, `SBS_LAT_2, 2'h0, 1'b0);
        host.wr_burst(12'h1f3, 8, 16'h2000);
        repeat (3) @(negedge mclk);
        for (int k = 0; k < 8; k++) begin
            exp_q.push_back({exp_col(9'h005, 8, 1'b0, k), 16'h1000 + 16'(k)});
        end
        for (int k = 0; k < 8; k++) begin
            exp_q.push_back({exp_col(9'h1f3, 8, 1'b1, k), 16'h2000 + 16'(k)});
        end
        check({wr_ready, arr_wr_valid}, 2'b01, "fifo full");
        n = 0;
        for (int t = 0; t < 80 && n < 16; t++) begin
            arr_wr_ready = (t % 3 != 0);
            if ((arr_wr_valid & arr_wr_ready) === 1'b1) begin
                check({arr_wr_addr, arr_wr_data}, exp_q[n], "write beat");
                n++;
            end
            @(negedge mclk);
        end
        check(n, 16, "beats drained");
        check({wr_ready, arr_wr_valid}, 2'b10, "fifo empty");
    endtask

    // write-burst bit set: a write touches one column only
    task automatic t_single_write();
        arr_wr_ready = 1'b0;
        host.load_mode(`SBS_BL_4, 1'b0, `SBS_LAT_2, 2'h0, 1'b1);
        host.wr_burst(12'h006, 4, 16'h3000);
        repeat (2) @(negedge mclk);
        check({arr_wr_valid, arr_wr_addr, arr_wr_data}, {1'b1, 9'h006, 16'h3000}, "single");
        arr_wr_ready = 1'b1;
        @(negedge mclk);
        check(arr_wr_valid, 1'b0, "one write only");
    endtask

    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    // main sequence
    initial begin
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_reads();
        t_page();
        t_refused();
        t_fifo();
        t_single_write();
        conclude();
    end
endmodule
`default_nettype wire
